// file: src/asmmr_ovr_mon.sv
`timescale 1ns/1ns
`default_nettype none
module asmmr_ovr_mon
  import asmmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ovr_pin,
  input wire logic det_en,
  input wire logic gain_change,
  output logic ovr_flag
);

  // Three-stage synchroniser for the analog detector
  logic [2:0] sync;
  logic [2:0] next_sync;
  // Debounced detector level
  logic ovr_level;
  logic next_ovr_level;
  // Interval timer
  logic [11:0] tick_cnt;
  logic [11:0] next_tick_cnt;
  logic next_ovr_flag;

  // Next-state computation
  always_comb begin
    next_sync = {sync[1:0], ovr_pin};
    // Accept a change only when stages two and three agree
    next_ovr_level = (sync[1] == sync[2]) ? sync[2] : ovr_level;
    next_tick_cnt = (tick_cnt == OVR_LAST) ? 12'h000 : tick_cnt + 12'h001;
    next_ovr_flag = ovr_flag;
    // clear on disable or gain change
    if (!det_en || gain_change) begin
      next_ovr_flag = 1'b0;
      next_tick_cnt = 12'h000;
    end else if (tick_cnt == OVR_LAST && ovr_level) begin
      next_ovr_flag = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sync <= 3'h0;
      ovr_level <= 1'b0;
      tick_cnt <= 12'h000;
      ovr_flag <= 1'b0;
    end else if (ce) begin
      sync <= next_sync;
      ovr_level <= next_ovr_level;
      tick_cnt <= next_tick_cnt;
      ovr_flag <= next_ovr_flag;
    end
  end

endmodule : asmmr_ovr_mon
`default_nettype wire

// file: src/asmmr_pkg.sv
// Contract
// - Current data read clears all ready flags
// - Current off: voltage/temperature read clears all
// - Hold data until its ready flag clears
// - Core powered down: always update data
// - Comparator sets bit 4 above threshold
// - Threshold counter: set when count reached
// - Overrange detect sets status bit 3
// - Overrange flag updated every 125 us
// - Overrange held until disabled or gain change
// - Temperature result sets bit 2, read clears
// - Voltage result sets bit 1, read clears
// - Current result sets bit 0, current read clears
// - Mask bit enables matching status source
// - Mask register resets to zero
// - Mode bit 6 selects 20k ground path
// - Mode bit 5 selects low-power reference
// - Mode bits 4:3 select power mode
// - Enabled low status bits ORed to interrupt
// - Power modes normal, low, low-plus, undefined
// - Mode bits 2:0 select operation
package asmmr_pkg;

  // Register addresses
  localparam logic [31:0] STATUS_ADDR = 32'hFFFF0500;
  localparam logic [31:0] IRQ_EN_ADDR = 32'hFFFF0504;
  localparam logic [31:0] MODE_ADDR = 32'h0FFF0508;
  localparam logic [31:0] CUR_DATA_ADDR = 32'hFFFF050C;
  localparam logic [31:0] VOLT_DATA_ADDR = 32'hFFFF0510;
  localparam logic [31:0] TEMP_DATA_ADDR = 32'hFFFF0514;

  // Status bit positions
  localparam int ST_CUR_RDY = 0;
  localparam int ST_VOLT_RDY = 1;
  localparam int ST_TEMP_RDY = 2;
  localparam int ST_OVR = 3;
  localparam int ST_THRESH = 4;

  // Mode field positions
  localparam int MD_RSVD = 7;
  localparam int MD_GND_RES = 6;
  localparam int MD_LP_REF = 5;
  localparam int MD_PWR_HI = 4;
  localparam int MD_PWR_LO = 3;
  localparam int MD_OP_HI = 2;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Overrange evaluation interval
  localparam int CLK_PERIOD_NS = 40;
  localparam int OVR_INTERVAL_NS = 125000;
  localparam int OVR_CYCLES = OVR_INTERVAL_NS / CLK_PERIOD_NS;
  localparam logic [11:0] OVR_LAST = 12'(OVR_CYCLES - 1);

  // Power mode encodings
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_LOW = 2'h1;
  localparam logic [1:0] PWR_LOW_PLUS = 2'h2;
  localparam logic [1:0] PWR_UNDEF = 2'h3;

  // Operation mode encodings
  localparam logic [2:0] OP_POWER_DOWN = 3'h0;
  localparam logic [2:0] OP_CONTINUOUS = 3'h1;
  localparam logic [2:0] OP_SINGLE = 3'h2;
  localparam logic [2:0] OP_IDLE = 3'h3;
  localparam logic [2:0] OP_OFFSET_CAL = 3'h4;
  localparam logic [2:0] OP_GAIN_CAL = 3'h5;

endpackage : asmmr_pkg

// file: src/asmmr_top.sv
`timescale 1ns/1ns
`default_nettype none
module asmmr_top
  import asmmr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  // Processor register port
  input wire logic [31:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [15:0] WDATA,
  output logic [15:0] RDATA,
  // Converter result strobes
  input wire logic CUR_VALID,
  input wire logic [15:0] CUR_RESULT,
  input wire logic VOLT_VALID,
  input wire logic [15:0] VOLT_RESULT,
  input wire logic TEMP_VALID,
  input wire logic [15:0] TEMP_RESULT,
  // Configuration levels
  input wire logic CUR_EN,
  input wire logic VOLT_EN,
  input wire logic TEMP_EN,
  input wire logic CMP_EN,
  input wire logic OVR_DET_EN,
  input wire logic GAIN_CHANGE,
  input wire logic CORE_POWERED_DOWN,
  input wire logic [15:0] CUR_THRESHOLD,
  input wire logic THRESH_COUNT_EN,
  input wire logic [7:0] THRESH_COUNT_LIMIT,
  // Analog overrange detector
  input wire logic OVR_DETECT,
  // Outputs
  output logic CONV_IRQ,
  output logic GND_SW_RES_SEL,
  output logic LP_REF_PRECISE,
  output logic [1:0] POWER_MODE,
  output logic [2:0] OP_MODE,
  output logic [7:0] THRESH_COUNT_VALUE
);

  // Mode, mask and status storage
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [7:0] irq_en;
  logic [7:0] next_irq_en;
  logic [4:0] ready;
  logic [4:0] next_ready;
  // Channel data registers
  logic [15:0] cur_data;
  logic [15:0] next_cur_data;
  logic [15:0] volt_data;
  logic [15:0] next_volt_data;
  logic [15:0] temp_data;
  logic [15:0] next_temp_data;
  // Read data register
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  // Threshold counter
  logic [7:0] th_cnt;
  logic [7:0] next_th_cnt;
  // Overrange flag from the monitor
  logic ovr_flag;
  // Decoded read strobes
  logic rd_cur;
  logic rd_volt;
  logic rd_temp;
  // Accepted data updates
  logic upd_cur;
  logic upd_volt;
  logic upd_temp;
  // Magnitude of the current result
  logic [15:0] cur_mag;
  logic cur_exceeds;
  // Full status word
  logic [15:0] status;

  // Overrange monitor
  asmmr_ovr_mon u_ovr (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CE),
    .ovr_pin(OVR_DETECT),
    .det_en(OVR_DET_EN),
    .gain_change(GAIN_CHANGE),
    .ovr_flag(ovr_flag)
  );

  // Read decode and update gating
  always_comb begin
    rd_cur = RD_EN && (ADDR == CUR_DATA_ADDR);
    rd_volt = RD_EN && (ADDR == VOLT_DATA_ADDR);
    rd_temp = RD_EN && (ADDR == TEMP_DATA_ADDR);
    upd_cur = CUR_VALID && CUR_EN && (!ready[ST_CUR_RDY] || CORE_POWERED_DOWN);
    upd_volt = VOLT_VALID && VOLT_EN && (!ready[ST_VOLT_RDY] || CORE_POWERED_DOWN);
    upd_temp = TEMP_VALID && TEMP_EN && (!ready[ST_TEMP_RDY] || CORE_POWERED_DOWN);
    // Two's complement magnitude
    cur_mag = CUR_RESULT[15] ? (~CUR_RESULT + 16'h0001) : CUR_RESULT;
    cur_exceeds = cur_mag > CUR_THRESHOLD;
    status = {11'h000, ready[ST_THRESH], ovr_flag, ready[ST_TEMP_RDY:ST_CUR_RDY]};
  end

  // Mode and mask register writes
  always_comb begin
    next_mode = mode;
    next_irq_en = irq_en;
    if (WR_EN && ADDR == MODE_ADDR) begin
      next_mode = WDATA[7:0];
      // Reserved bit stored as zero
      next_mode[MD_RSVD] = 1'b0;
    end
    if (WR_EN && ADDR == IRQ_EN_ADDR) begin
      next_irq_en = WDATA[7:0];
    end
  end

  // Ready flags, data registers and threshold counter
  always_comb begin
    next_ready = ready;
    next_cur_data = cur_data;
    next_volt_data = volt_data;
    next_temp_data = temp_data;
    next_th_cnt = th_cnt;
    // current read clears every ready flag
    if (rd_cur) begin
      next_ready[ST_TEMP_RDY:ST_CUR_RDY] = 3'h0;
    end
    // current off, other reads clear all
    if ((rd_volt || rd_temp) && !CUR_EN) begin
      next_ready[ST_TEMP_RDY:ST_CUR_RDY] = 3'h0;
    end
    if (rd_volt) begin
      next_ready[ST_VOLT_RDY] = 1'b0;
    end
    if (rd_temp) begin
      next_ready[ST_TEMP_RDY] = 1'b0;
    end
    if (upd_cur) begin
      next_cur_data = CUR_RESULT;
      next_ready[ST_CUR_RDY] = 1'b1;
    end
    if (upd_volt) begin
      next_volt_data = VOLT_RESULT;
      next_ready[ST_VOLT_RDY] = 1'b1;
    end
    if (upd_temp) begin
      next_temp_data = TEMP_RESULT;
      next_ready[ST_TEMP_RDY] = 1'b1;
    end
    // Comparator off clears flag and count
    if (!CMP_EN) begin
      next_ready[ST_THRESH] = 1'b0;
      next_th_cnt = 8'h00;
    end else if (CUR_VALID && CUR_EN && cur_exceeds) begin
      if (THRESH_COUNT_EN) begin
        if (th_cnt != 8'hFF) begin
          next_th_cnt = th_cnt + 8'h01;
        end
        if (th_cnt + 8'h01 == THRESH_COUNT_LIMIT) begin
          next_ready[ST_THRESH] = 1'b1;
        end
      end else begin
        next_ready[ST_THRESH] = 1'b1;
      end
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = rdata;
    if (RD_EN) begin
      case (ADDR)
        STATUS_ADDR: next_rdata = status;
        IRQ_EN_ADDR: next_rdata = {8'h00, irq_en};
        MODE_ADDR: next_rdata = {8'h00, mode};
        CUR_DATA_ADDR: next_rdata = cur_data;
        VOLT_DATA_ADDR: next_rdata = volt_data;
        TEMP_DATA_ADDR: next_rdata = temp_data;
        // Unmapped addresses read zero
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode <= MODE_RESET;
      irq_en <= IRQ_EN_RESET;
      ready <= 5'h00;
      cur_data <= DATA_RESET;
      volt_data <= DATA_RESET;
      temp_data <= DATA_RESET;
      rdata <= STATUS_RESET;
      th_cnt <= 8'h00;
    end else if (CE) begin
      mode <= next_mode;
      irq_en <= next_irq_en;
      ready <= next_ready;
      cur_data <= next_cur_data;
      volt_data <= next_volt_data;
      temp_data <= next_temp_data;
      rdata <= next_rdata;
      th_cnt <= next_th_cnt;
    end
  end

  // Outputs
  always_comb begin
    RDATA = rdata;
    // OR of enabled low status bits
    CONV_IRQ = |(status[7:0] & irq_en);
    GND_SW_RES_SEL = mode[MD_GND_RES];
    LP_REF_PRECISE = mode[MD_LP_REF];
    // 01 low, 10 low plus, 11 undefined
    POWER_MODE = mode[MD_PWR_HI:MD_PWR_LO];
    OP_MODE = mode[MD_OP_HI:0];
    THRESH_COUNT_VALUE = th_cnt;
  end

endmodule : asmmr_top
`default_nettype wire

// file: test/asmmr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module asmmr_core_model
  import asmmr_pkg::*;
(
  input wire logic clk,
  output logic [31:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 16'h0000;
  end

  // One register access, answer taken after the sampling edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= (a == MODE_ADDR) ? (d & 16'hFF7F) : d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : acc
endmodule : asmmr_core_model
`default_nettype wire

// file: test/asmmr_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module asmmr_chk
  import asmmr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [31:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [15:0] WDATA,
  input wire logic [15:0] RDATA,
  input wire logic CUR_VALID,
  input wire logic VOLT_VALID,
  input wire logic TEMP_VALID,
  input wire logic CUR_EN,
  input wire logic VOLT_EN,
  input wire logic CMP_EN,
  input wire logic OVR_DET_EN,
  input wire logic CONV_IRQ,
  input wire logic GND_SW_RES_SEL,
  input wire logic LP_REF_PRECISE,
  input wire logic [1:0] POWER_MODE,
  input wire logic [2:0] OP_MODE
);
  // Running cycle with no result strobes
  wire logic quiet = CE && !CUR_VALID && !VOLT_VALID && !TEMP_VALID;
  // Status read request
  wire logic st_rd = quiet && RD_EN && ADDR == STATUS_ADDR;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  AST_IRQ_RESET: assert property ($fell(RST) |-> !CONV_IRQ) else $error("irq high after reset");
  AST_CUR_CLR: assert property ((quiet && RD_EN && ADDR == CUR_DATA_ADDR) ##1 quiet ##1 st_rd
    |=> RDATA[2:0] == 3'h0) else $error("ready left after current read");
  AST_ALT_CLR: assert property ((quiet && !CUR_EN && RD_EN && ADDR == TEMP_DATA_ADDR) ##1 quiet ##1 st_rd
    |=> RDATA[2:0] == 3'h0) else $error("ready left after temperature read");
  AST_IRQ_MASK: assert property ((CE && WR_EN && ADDR == IRQ_EN_ADDR && WDATA[7:0] == 8'h00)
    |=> !CONV_IRQ) else $error("irq with empty mask");
  AST_CUR_SET: assert property ((CE && CUR_VALID && CUR_EN) ##1 (quiet && !RD_EN) ##1 st_rd |=> RDATA[0])
    else $error("current ready not set");
  AST_VOLT_SET: assert property ((CE && VOLT_VALID && VOLT_EN) ##1 (quiet && !RD_EN) ##1 st_rd |=> RDATA[1])
    else $error("voltage ready not set");
  AST_MODE_OUT: assert property ((CE && WR_EN && ADDR == MODE_ADDR)
    |=> {GND_SW_RES_SEL, LP_REF_PRECISE, POWER_MODE, OP_MODE} == $past(WDATA[6:0])) else $error("mode mismatch");
  AST_MODE_RSVD: assert property ((CE && RD_EN && ADDR == MODE_ADDR) |=> RDATA[15:7] == 9'h000)
    else $error("mode upper bits set");
  AST_OVR_OFF: assert property ((CE && !OVR_DET_EN) ##1 st_rd |=> !RDATA[3])
    else $error("overrange kept while disabled");
  AST_CMP_OFF: assert property ((CE && !CMP_EN) ##1 st_rd |=> !RDATA[4])
    else $error("threshold kept while disabled");
endmodule : asmmr_chk
bind asmmr_top asmmr_chk chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WR_EN(WR_EN),
  .RD_EN(RD_EN), .WDATA(WDATA), .RDATA(RDATA), .CUR_VALID(CUR_VALID), .VOLT_VALID(VOLT_VALID),
  .TEMP_VALID(TEMP_VALID), .CUR_EN(CUR_EN), .VOLT_EN(VOLT_EN), .CMP_EN(CMP_EN), .OVR_DET_EN(OVR_DET_EN),
  .CONV_IRQ(CONV_IRQ), .GND_SW_RES_SEL(GND_SW_RES_SEL), .LP_REF_PRECISE(LP_REF_PRECISE),
  .POWER_MODE(POWER_MODE), .OP_MODE(OP_MODE));
`default_nettype wire

// file: test/test_asmmr_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_asmmr_top
  import asmmr_pkg::*;
;
  // Mode write beside expected mode outputs
  typedef struct packed {logic [7:0] wd; logic [6:0] outs;} asmmr_row_t;
  asmmr_row_t rows [6] = '{'{8'h00, 7'h00}, '{8'h09, 7'h09}, '{8'h12, 7'h12}, '{8'h1B, 7'h1B},
    '{8'h64, 7'h64}, '{8'h45, 7'h45}};
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic cur_v = 1'b0, volt_v = 1'b0, temp_v = 1'b0, cur_en = 1'b1, volt_en = 1'b1, temp_en = 1'b1;
  logic cmp_en = 1'b0, ovr_en = 1'b0, gain_chg = 1'b0, pd = 1'b0, cnt_en = 1'b0, ovr_in = 1'b0;
  logic [15:0] cur_r = 16'h0000, volt_r = 16'h0000, temp_r = 16'h0000, thr = 16'h7FFF, q;
  logic [7:0] lim = 8'h00;
  wire logic [31:0] addr;
  wire logic wr_en, rd_en, irq, gsw, lpref;
  wire logic [15:0] wdata, rdata;
  wire logic [1:0] pmode;
  wire logic [2:0] opm;
  wire logic [7:0] cnt;
  int mismatches = 0;
  int checked = 0;

  always #20 clk = ~clk;

  asmmr_core_model core_u (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata));
  asmmr_top dut_u (.CORE_CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
    .WDATA(wdata), .RDATA(rdata), .CUR_VALID(cur_v), .CUR_RESULT(cur_r), .VOLT_VALID(volt_v),
    .VOLT_RESULT(volt_r), .TEMP_VALID(temp_v), .TEMP_RESULT(temp_r), .CUR_EN(cur_en), .VOLT_EN(volt_en),
    .TEMP_EN(temp_en), .CMP_EN(cmp_en), .OVR_DET_EN(ovr_en), .GAIN_CHANGE(gain_chg), .CORE_POWERED_DOWN(pd),
    .CUR_THRESHOLD(thr), .THRESH_COUNT_EN(cnt_en), .THRESH_COUNT_LIMIT(lim), .OVR_DETECT(ovr_in),
    .CONV_IRQ(irq), .GND_SW_RES_SEL(gsw), .LP_REF_PRECISE(lpref), .POWER_MODE(pmode), .OP_MODE(opm),
    .THRESH_COUNT_VALUE(cnt));

  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    core_u.acc(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    core_u.acc(1'b1, a, d, q);
  endtask : wr

  // One-cycle result strobes, bit 0 current, 1 voltage, 2 temperature
  task automatic pulse(input logic [2:0] m, input logic [15:0] v);
    @(posedge clk);
    {temp_v, volt_v, cur_v} <= m;
    {cur_r, volt_r, temp_r} <= {v, v, v};
    @(posedge clk);
    {temp_v, volt_v, cur_v} <= 3'h0;
    @(negedge clk);
  endtask : pulse

  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // Hang guard
  initial begin
    repeat (14000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(IRQ_EN_ADDR, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    foreach (rows[i]) begin
      wr(MODE_ADDR, {8'h00, rows[i].wd});
      chk({9'h0, gsw, lpref, pmode, opm}, {9'h0, rows[i].outs});
      rd(MODE_ADDR, {9'h0, rows[i].outs});
    end
    rd(32'hFFFF05F0, 16'h0000);
    wr(STATUS_ADDR, 16'hFFFF);
    rd(STATUS_ADDR, 16'h0000);
    // Clock enable low drops a result strobe
    @(posedge clk) ce <= 1'b0;
    pulse(3'b001, 16'h4321);
    @(posedge clk) ce <= 1'b1;
    rd(STATUS_ADDR, 16'h0000);
    pulse(3'b011, 16'h1234);
    rd(STATUS_ADDR, 16'h0003);
    pulse(3'b010, 16'h5555);
    rd(VOLT_DATA_ADDR, 16'h1234);
    rd(STATUS_ADDR, 16'h0001);
    pulse(3'b100, 16'h0777);
    rd(STATUS_ADDR, 16'h0005);
    rd(CUR_DATA_ADDR, 16'h1234);
    rd(STATUS_ADDR, 16'h0000);
    wr(IRQ_EN_ADDR, 16'h0004);
    pulse(3'b100, 16'h0888);
    chk({15'h0, irq}, 16'h0001);
    wr(IRQ_EN_ADDR, 16'h0003);
    chk({15'h0, irq}, 16'h0000);
    rd(TEMP_DATA_ADDR, 16'h0888);
    wr(IRQ_EN_ADDR, 16'h0000);
    @(posedge clk) cur_en <= 1'b0;
    pulse(3'b111, 16'h0ABC);
    rd(STATUS_ADDR, 16'h0006);
    rd(TEMP_DATA_ADDR, 16'h0ABC);
    rd(STATUS_ADDR, 16'h0000);
    @(posedge clk) {pd, cur_en} <= 2'b11;
    pulse(3'b010, 16'h1111);
    pulse(3'b010, 16'h2222);
    rd(VOLT_DATA_ADDR, 16'h2222);
    @(posedge clk) {pd, cmp_en, thr} <= {2'b01, 16'h0100};
    pulse(3'b001, 16'h0100);
    rd(STATUS_ADDR, 16'h0001);
    pulse(3'b001, 16'hFE00);
    rd(STATUS_ADDR, 16'h0011);
    @(posedge clk) {cmp_en, cnt_en, lim} <= {2'b01, 8'h03};
    @(posedge clk) cmp_en <= 1'b1;
    pulse(3'b001, 16'h0200);
    pulse(3'b001, 16'h0200);
    rd(STATUS_ADDR, 16'h0001);
    pulse(3'b001, 16'h0200);
    rd(STATUS_ADDR, 16'h0011);
    chk({8'h00, cnt}, 16'h0003);
    @(posedge clk) cmp_en <= 1'b0;
    rd(CUR_DATA_ADDR, 16'h0100);
    @(posedge clk) {ovr_en, ovr_in, gain_chg} <= 3'b111;
    @(posedge clk) gain_chg <= 1'b0;
    repeat (3000) @(posedge clk);
    rd(STATUS_ADDR, 16'h0000);
    repeat (200) @(posedge clk);
    rd(STATUS_ADDR, 16'h0008);
    @(posedge clk) ovr_in <= 1'b0;
    repeat (3200) @(posedge clk);
    rd(STATUS_ADDR, 16'h0008);
    @(posedge clk) {ovr_in, gain_chg} <= 2'b11;
    @(posedge clk) gain_chg <= 1'b0;
    rd(STATUS_ADDR, 16'h0000);
    repeat (3200) @(posedge clk);
    rd(STATUS_ADDR, 16'h0008);
    @(posedge clk) ovr_en <= 1'b0;
    rd(STATUS_ADDR, 16'h0000);
    wrap_up();
  end
endmodule : test_asmmr_top
`default_nettype wire
